/* File: hw/icr_defines.vh */
// Register offsets, field positions, reset values and timing for the context block
`ifndef ICR_DEFINES_VH
`define ICR_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define ICR_OFS_CONTEXT     8'h00
`define ICR_OFS_CONTROL     8'h04
`define ICR_OFS_VECTOR      8'h08
`define ICR_OFS_VECOUT      8'h0C
`define ICR_OFS_GBYTECNT    8'h10
`define ICR_OFS_GCHAN       8'h14
`define ICR_OFS_GCHANALIAS  8'h18
`define ICR_OFS_GTYPE       8'h1C
`define ICR_OFS_GRXDATA     8'h20
`define ICR_OFS_GTXDATA     8'h24
`define ICR_OFS_GSTAT       8'h28
`define ICR_OFS_GMASK       8'h2C
`define ICR_OFS_GMODE       8'h30
`define ICR_OFS_GCTX        8'h34
`define ICR_OFS_RECOG       8'h38
`define ICR_OFS_MODE0       8'h3C
`define ICR_OFS_XON         8'h40
`define ICR_OFS_XOFF        8'h44
`define ICR_OFS_ADDRCH      8'h48
`define ICR_OFS_RECENT      8'h4C

// ****************************************
// Control register fields
// ****************************************
`define ICR_CTL_THR_LSB     0
`define ICR_CTL_THR_MSB     10
`define ICR_CTL_VMOD_BIT    11
`define ICR_CTL_VFIX_BIT    12

// ****************************************
// Bid layout
// ****************************************
`define ICR_BID_CH_BIT      0
`define ICR_BID_TYPE_LSB    1
`define ICR_BID_TYPE_MSB    4
`define ICR_TYPE_RX_OK      4'h2
`define ICR_TYPE_RX_ERR     4'hA
`define ICR_TYPE_RX_WD      4'h8
`define ICR_TYPE_TX         4'h4
`define ICR_TYPE_CT         4'h0
`define ICR_TYPE_CT_HI      1'b1
`define ICR_TYPE_COS        4'h6

// ****************************************
// Recognition fields
// ****************************************
`define ICR_MODE0_STRIP_LSB 6
`define ICR_STRIP_NONE      2'h0
`define ICR_STRIP_XONOFF    2'h1
`define ICR_STRIP_ADDR      2'h2
`define ICR_STRIP_ALL       2'h3

// ****************************************
// Reset values
// ****************************************
`define ICR_RST_XON         8'h11
`define ICR_RST_XOFF        8'h13
`define ICR_RST_ADDR        8'h00
`define ICR_RST_VECTOR      8'h0F
`define ICR_FIXED_VECTOR    8'h0F

// ****************************************
// Timing
// ****************************************
`define ICR_ARB_PERIOD      2

`endif

/* File: hw/icr_context.v */
// Interrupt context capture, vectoring, global registers and character recognition
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "icr_defines.vh"

// Overview of operation
// - Acknowledge latches winning bid into context
// - Acknowledge answered with fixed/programmed/modified vector
// - Context held until next capture event or soft reset
// - No bid above threshold loads zero
// - Modified vector context bits zero when idle
// - Ten global registers indexed by context
// - Global byte count gives interrupting FIFO level
// - Global channel zero except timer1, port B
// - Global type returns captured type code
// - Global data routed to interrupting FIFO
// - Update-context write captures like acknowledge
// - Context readable at update-context address
// - Zero type means nothing pending
// - Three match characters compared continuously
// - Match sets recognition and status bits
// - Reading recognition status clears it
// - Reset reloads flow-control match characters
// - Two-bit field selects stripping
// - Actions fire whether stripped or not
// - Errored match character still stored
// - New candidate every two clocks
// - Pending only when bid exceeds threshold
// - Resume 0x11, stop 0x13 defaults
module icr_context (
	input  wire        pclk,         // System clock
	input  wire        presetn,      // Async reset, active low
	input  wire        psel,         // APB select
	input  wire        penable,      // APB enable
	input  wire        pwrite,       // APB direction
	input  wire [7:0]  paddr,        // APB byte address
	input  wire [31:0] pwdata,       // APB write data
	output reg  [31:0] prdata,       // APB read data
	output reg         pready,       // APB ready
	output reg         pslverr,      // APB error, unmapped address
	input  wire        soft_reset,   // Software reset pulse
	input  wire        irq_ack_n,    // Host acknowledge, active low
	output reg  [7:0]  irq_vector,   // Vector for the acknowledge cycle
	output reg         irq_vec_vld,  // Vector valid pulse
	output reg         irq_request_n,// Request pending, active low
	input  wire [11:0] bid_rx,       // Receiver bid
	input  wire [11:0] bid_tx,       // Transmitter bid
	input  wire [11:0] bid_misc,     // Highest non-FIFO bid
	input  wire [7:0]  rx_level,     // Receive FIFO fill
	input  wire [7:0]  tx_level,     // Transmit FIFO empty count
	input  wire [7:0]  rx_fifo_data, // Head of receive FIFO
	output reg         rx_fifo_pop,  // Receive FIFO pop pulse
	output reg  [7:0]  tx_fifo_data, // Data for transmit FIFO
	output reg         tx_fifo_push, // Transmit FIFO push pulse
	input  wire        ch_valid,     // Incoming character strobe
	input  wire [7:0]  ch_data,      // Incoming character
	input  wire        ch_err,       // Character carries error flag
	output reg         ch_store,     // Write character to receive FIFO
	output reg  [7:0]  ch_store_data,// Character to store
	output reg  [2:0]  recog_event,  // Match pulses: xon, xoff, addr
	output reg  [2:0]  irq_status_set// Status bits set on match
);

	// ****************************************
	// Registers
	// ****************************************
	reg  [11:0] current_context_reg_q;
	reg  [12:0] irq_control_reg_q;
	reg  [7:0]  vector_q;
	reg  [7:0]  mode_reg_zero_q;
	reg  [7:0]  xon_q;
	reg  [7:0]  xoff_q;
	reg  [7:0]  addr_q;
	reg  [2:0]  recog_status_reg_q;
	reg  [7:0]  last_match_q;
	reg  [11:0] cand_q;
	reg         phase_q;
	reg         ack_s1_q;
	reg         ack_s2_q;
	reg         ack_s3_q;

	wire        wr_en;
	wire        rd_en;
	wire        ack_fall;
	wire        upd_cmd;
	wire        capture;
	wire [10:0] thr;
	wire [11:0] winner;
	wire [3:0]  ctx_type;
	wire        ctx_ch;
	wire        ctx_is_rx;
	wire        ctx_is_tx;
	wire [2:0]  match;
	wire        strip_hit;
	wire [7:0]  vec_mod;

	assign wr_en   = psel & penable & pwrite & pready;
	assign rd_en   = psel & penable & ~pwrite & pready;
	assign upd_cmd = wr_en & (paddr == `ICR_OFS_CONTEXT);
	assign ack_fall = ack_s3_q & ~ack_s2_q;
	assign capture  = ack_fall | upd_cmd;
	assign thr      = irq_control_reg_q[`ICR_CTL_THR_MSB:`ICR_CTL_THR_LSB];

	// ****************************************
	// Arbitration candidate
	// ****************************************
	// Threshold bit 0 lines up with bid bit 1
	function [11:0] icr_max;
		input [11:0] a;
		input [11:0] b;
		begin
			icr_max = (a > b) ? a : b;
		end
	endfunction

	assign winner = icr_max(icr_max(bid_rx, bid_tx), bid_misc);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q <= 1'b0;
			cand_q  <= 12'h000;
		end else begin
			phase_q <= ~phase_q;
			if (phase_q) begin
				if (winner[11:1] > thr)
					cand_q <= winner;
				else
					cand_q <= 12'h000;
			end
		end
	end

	// ****************************************
	// Acknowledge synchroniser and capture
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_s1_q <= 1'b1;
			ack_s2_q <= 1'b1;
			ack_s3_q <= 1'b1;
			current_context_reg_q <= 12'h000;
		end else begin
			ack_s1_q <= irq_ack_n;
			ack_s2_q <= ack_s1_q;
			ack_s3_q <= ack_s2_q;
			if (soft_reset)
				current_context_reg_q <= 12'h000;
			else if (capture)
				current_context_reg_q <= cand_q;
		end
	end

	assign ctx_type  = current_context_reg_q[`ICR_BID_TYPE_MSB:`ICR_BID_TYPE_LSB];
	assign ctx_ch    = current_context_reg_q[`ICR_BID_CH_BIT];
	assign ctx_is_rx = (ctx_type == `ICR_TYPE_RX_OK) | (ctx_type == `ICR_TYPE_RX_ERR) |
		(ctx_type == `ICR_TYPE_RX_WD);
	assign ctx_is_tx = (ctx_type == `ICR_TYPE_TX);
	// Context bits come from the register, so zero context gives zero bits
	assign vec_mod = {vector_q[7:5], ctx_type, ctx_ch};

	// ****************************************
	// Vector answer
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_vector    <= 8'h00;
			irq_vec_vld   <= 1'b0;
			irq_request_n <= 1'b1;
		end else begin
			irq_request_n <= (cand_q[`ICR_BID_TYPE_MSB:`ICR_BID_TYPE_LSB] == 4'h0);
			irq_vec_vld   <= ack_fall;
			if (ack_fall) begin
				if (irq_control_reg_q[`ICR_CTL_VFIX_BIT])
					irq_vector <= `ICR_FIXED_VECTOR;
				else if (irq_control_reg_q[`ICR_CTL_VMOD_BIT])
					irq_vector <= {vector_q[7:5], cand_q[4:1], cand_q[0]};
				else
					irq_vector <= vector_q;
			end
		end
	end

	// ****************************************
	// Character recognition
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_cmp
			wire [7:0] ref_ch;
			assign ref_ch = (gi == 0) ? xon_q : (gi == 1) ? xoff_q : addr_q;
			assign match[gi] = ch_valid & (ch_data == ref_ch);
		end
	endgenerate

	assign strip_hit =
		((mode_reg_zero_q[7:6] == `ICR_STRIP_XONOFF) & (match[0] | match[1])) |
		((mode_reg_zero_q[7:6] == `ICR_STRIP_ADDR) & match[2]) |
		((mode_reg_zero_q[7:6] == `ICR_STRIP_ALL) & (|match));

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch_store       <= 1'b0;
			ch_store_data  <= 8'h00;
			recog_event    <= 3'h0;
			irq_status_set <= 3'h0;
			last_match_q   <= 8'h00;
		end else begin
			ch_store       <= ch_valid & (~strip_hit | ch_err);
			ch_store_data  <= ch_data;
			recog_event    <= match;
			irq_status_set <= match;
			if (|match)
				last_match_q <= ch_data;
		end
	end

	// ****************************************
	// APB register file
	// ****************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_control_reg_q  <= 13'h0000;
			vector_q           <= `ICR_RST_VECTOR;
			mode_reg_zero_q    <= 8'h00;
			xon_q              <= `ICR_RST_XON;
			xoff_q             <= `ICR_RST_XOFF;
			addr_q             <= `ICR_RST_ADDR;
			recog_status_reg_q <= 3'h0;
			pready             <= 1'b0;
			pslverr            <= 1'b0;
			prdata             <= 32'h0000_0000;
			rx_fifo_pop        <= 1'b0;
			tx_fifo_push       <= 1'b0;
			tx_fifo_data       <= 8'h00;
		end else begin
			// One wait state: ready rises at the end of the first access cycle
			pready       <= psel & penable & ~pready;
			pslverr      <= 1'b0;
			rx_fifo_pop  <= 1'b0;
			tx_fifo_push <= 1'b0;
			if (soft_reset) begin
				xon_q  <= `ICR_RST_XON;
				xoff_q <= `ICR_RST_XOFF;
			end
			if (psel & penable & ~pready) begin
				prdata <= 32'h0000_0000;
				case (paddr)
					`ICR_OFS_CONTEXT:    prdata[11:0] <= current_context_reg_q;
					`ICR_OFS_CONTROL:    prdata[12:0] <= irq_control_reg_q;
					`ICR_OFS_VECTOR:     prdata[7:0]  <= vector_q;
					`ICR_OFS_VECOUT:     prdata[7:0]  <= vec_mod;
					`ICR_OFS_GBYTECNT:   prdata[7:0]  <= ctx_is_rx ? rx_level :
						(ctx_is_tx ? tx_level : 8'h00);
					`ICR_OFS_GCHAN, `ICR_OFS_GCHANALIAS:
						prdata[0] <= ctx_ch & ((ctx_type == `ICR_TYPE_CT) |
							(ctx_type == `ICR_TYPE_COS));
					`ICR_OFS_GTYPE:      prdata[3:0]  <= ctx_type;
					`ICR_OFS_GRXDATA:    prdata[7:0]  <= rx_fifo_data;
					`ICR_OFS_GTXDATA:    prdata[7:0]  <= tx_level;
					`ICR_OFS_GSTAT:      prdata[0]    <= ~irq_request_n;
					`ICR_OFS_GMASK:      prdata[10:0] <= thr;
					`ICR_OFS_GMODE:      prdata[7:0]  <= mode_reg_zero_q;
					`ICR_OFS_GCTX:       prdata[11:0] <= cand_q;
					`ICR_OFS_RECOG:      prdata[2:0]  <= recog_status_reg_q;
					`ICR_OFS_MODE0:      prdata[7:0]  <= mode_reg_zero_q;
					`ICR_OFS_XON:        prdata[7:0]  <= xon_q;
					`ICR_OFS_XOFF:       prdata[7:0]  <= xoff_q;
					`ICR_OFS_ADDRCH:     prdata[7:0]  <= addr_q;
					`ICR_OFS_RECENT:     prdata[7:0]  <= last_match_q;
					default:             pslverr      <= 1'b1;
				endcase
			end
			// Match beats a same-cycle read clear
			if (rd_en & (paddr == `ICR_OFS_RECOG))
				recog_status_reg_q <= match;
			else
				recog_status_reg_q <= recog_status_reg_q | match;
			if (rd_en & (paddr == `ICR_OFS_GRXDATA) & ctx_is_rx)
				rx_fifo_pop <= 1'b1;
			if (wr_en) begin
				case (paddr)
					`ICR_OFS_CONTROL: irq_control_reg_q <= pwdata[12:0];
					`ICR_OFS_VECTOR:  vector_q          <= pwdata[7:0];
					`ICR_OFS_MODE0:   mode_reg_zero_q   <= pwdata[7:0];
					`ICR_OFS_XON:     xon_q             <= pwdata[7:0];
					`ICR_OFS_XOFF:    xoff_q            <= pwdata[7:0];
					`ICR_OFS_ADDRCH:  addr_q            <= pwdata[7:0];
					`ICR_OFS_GTXDATA: begin
						tx_fifo_data <= pwdata[7:0];
						tx_fifo_push <= ctx_is_tx;
					end
					default: ;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

/* File: tb/icr_host_model.sv */
// Host side model: acknowledges requests and collects the vector
`timescale 1ns/1ps
`default_nettype none
module icr_host_model (
	input  wire logic       pclk,        // System clock
	input  wire logic [7:0] irq_vector,  // Vector in
	input  wire logic       irq_vec_vld, // Vector valid
	output var  logic       irq_ack_n    // Acknowledge, low active
);
	initial irq_ack_n = 1'b1;
	// Hold sets how slow the host is; low always spans the vector latency
	task automatic ack(input int hold, output logic [7:0] vec, output logic got);
		int n;
		got = 1'b0;
		vec = 8'h00;
		@(posedge pclk);
		irq_ack_n <= 1'b0;
		for (n = 0; n < 8 + hold; n++) begin
			@(posedge pclk);
			if (irq_vec_vld === 1'b1) begin
				got = 1'b1;
				vec = irq_vector;
			end
		end
		irq_ack_n <= 1'b1;
		// High long enough to re-arm the edge detector
		repeat (3) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

/* File: tb/icr_context_asserts.sv */
// Concurrent checks on the ports of the context block
`timescale 1ns/1ps
`default_nettype none
`include "icr_defines.vh"
module icr_context_asserts (
	input wire logic       pclk,           // Clock
	input wire logic       presetn,        // Reset, low
	input wire logic       psel,           // Select
	input wire logic       penable,        // Enable
	input wire logic       pwrite,         // Direction
	input wire logic [7:0] paddr,          // Address
	input wire logic       pready,         // Ready
	input wire logic       irq_ack_n,      // Ack, low
	input wire logic       irq_vec_vld,    // Vector valid
	input wire logic       ch_valid,       // Char strobe
	input wire logic [7:0] ch_data,        // Char
	input wire logic       ch_err,         // Char error
	input wire logic       ch_store,       // Store strobe
	input wire logic [7:0] ch_store_data,  // Stored char
	input wire logic [2:0] recog_event,    // Match pulses
	input wire logic [2:0] irq_status_set, // Status pulses
	input wire logic       rx_fifo_pop,    // Rx pop
	input wire logic       tx_fifo_push    // Tx push
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_access_start;
		$rose(penable) && psel;
	endsequence
	sequence s_plain_char;
		ch_valid ##1 (recog_event == 3'h0);
	endsequence
	a_ready_wait: assert property (s_access_start |=> pready)
		else $error("ready not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_ack_vector: assert property ($fell(irq_ack_n) |-> ##[1:6] irq_vec_vld)
		else $error("no vector after acknowledge");
	a_vector_once: assert property (irq_vec_vld |=> !irq_vec_vld)
		else $error("vector valid repeated");
	a_plain_stored: assert property (s_plain_char |-> ch_store)
		else $error("ordinary character dropped");
	a_err_stored: assert property (ch_valid && ch_err |=> ch_store && ch_store_data == $past(ch_data))
		else $error("errored character not stored");
	a_event_cause: assert property (recog_event != 3'h0 |-> $past(ch_valid))
		else $error("match without character");
	a_status_same: assert property (recog_event != 3'h0 |-> irq_status_set == recog_event)
		else $error("status bits differ from match");
	a_pop_cause: assert property (rx_fifo_pop |-> $past(psel && !pwrite && paddr == `ICR_OFS_GRXDATA))
		else $error("pop without global read");
	a_push_cause: assert property (tx_fifo_push |-> $past(psel && pwrite && paddr == `ICR_OFS_GTXDATA))
		else $error("push without global write");
endmodule
bind icr_context icr_context_asserts i_icr_context_asserts (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pready, .irq_ack_n, .irq_vec_vld, .ch_valid, .ch_data, .ch_err, .ch_store,
	.ch_store_data, .recog_event, .irq_status_set, .rx_fifo_pop, .tx_fifo_push);
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the interrupt context block
`timescale 1ns/1ps
`default_nettype none
`include "icr_defines.vh"
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, soft_reset, pready, pslverr, er, ok;
	logic        irq_ack_n, irq_vec_vld, irq_request_n, rx_fifo_pop, tx_fifo_push;
	logic        ch_valid, ch_err, ch_store;
	logic [7:0]  paddr, rx_level, tx_level, rx_fifo_data, tx_fifo_data, ch_data;
	logic [7:0]  irq_vector, ch_store_data, v, vv;
	logic [31:0] pwdata, prdata, rd;
	logic [11:0] bid_rx, bid_tx, bid_misc, ctx;
	logic [10:0] thr;
	logic [2:0]  recog_event, irq_status_set;
	logic [1:0]  md;
	logic [7:0]  chars [3] = '{8'h11, 8'h13, 8'h55};
	int          err_count, n_checks;
	icr_context i_icr_context (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .soft_reset, .irq_ack_n, .irq_vector, .irq_vec_vld, .irq_request_n,
		.bid_rx, .bid_tx, .bid_misc, .rx_level, .tx_level, .rx_fifo_data, .rx_fifo_pop,
		.tx_fifo_data, .tx_fifo_push, .ch_valid, .ch_data, .ch_err, .ch_store, .ch_store_data,
		.recog_event, .irq_status_set);
	icr_host_model i_icr_host_model (.pclk, .irq_vector, .irq_vec_vld, .irq_ack_n);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	function automatic logic [11:0] exp_ctx(input logic [11:0] a, b, c, input logic [10:0] t);
		logic [11:0] m;
		m = (b > a) ? b : a;
		m = (c > m) ? c : m;
		return (m[11:1] > t) ? m : 12'h000;
	endfunction
	function automatic logic [7:0] exp_vec(input logic [7:0] r, input logic [11:0] c, input logic [1:0] s);
		if (s == 2'd2) return `ICR_FIXED_VECTOR;
		return (s == 2'd1) ? {r[7:5], c[4:0]} : r;
	endfunction
	function automatic logic strip(input int m, input int k);
		return m == 3 || (m == 1 && k < 2) || (m == 2 && k == 2);
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n == 20) chk("pready", 32'h1, 32'(pready));
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic send(input logic [7:0] c, input logic e);
		@(posedge pclk);
		ch_valid <= 1'b1;
		ch_data  <= c;
		ch_err   <= e;
		@(posedge pclk);
		ch_valid <= 1'b0;
		#1;
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Budget well above the few thousand cycles the sequence needs
	initial begin
		#500000;
		err_count++;
		print_verdict();
	end
	initial begin
		{psel, penable, pwrite, soft_reset, ch_valid, ch_err, presetn} = '0;
		{paddr, pwdata, ch_data, bid_rx, bid_tx, bid_misc, rx_level, tx_level, rx_fifo_data} = '0;
		err_count = 0;
		n_checks = 0;
		void'($urandom(43));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `ICR_OFS_CONTEXT, 32'h0);
		chk("context", 32'h0, rd);
		apb(1'b0, `ICR_OFS_VECTOR, 32'h0);
		chk("vector_reg", 32'h0F, rd);
		apb(1'b0, 8'hFC, 32'h0);
		chk("slverr", 32'h1, 32'(er));
		apb(1'b1, `ICR_OFS_XON, 32'h22);
		@(posedge pclk);
		soft_reset <= 1'b1;
		@(posedge pclk);
		soft_reset <= 1'b0;
		apb(1'b0, `ICR_OFS_XON, 32'h0);
		chk("xon", 32'h11, rd);
		apb(1'b0, `ICR_OFS_XOFF, 32'h0);
		chk("xoff", 32'h13, rd);
		for (int i = 0; i < 30; i++) begin
			md = 2'((i + 1) % 3);
			@(posedge pclk);
			bid_rx       <= {7'($urandom), `ICR_TYPE_RX_OK, 1'b0};
			bid_tx       <= {7'($urandom), `ICR_TYPE_TX, 1'b0};
			bid_misc     <= {7'($urandom), `ICR_TYPE_COS, 1'($urandom)};
			rx_level     <= 8'($urandom);
			tx_level     <= 8'($urandom);
			rx_fifo_data <= 8'($urandom);
			@(posedge pclk);
			ctx = exp_ctx(bid_rx, bid_tx, bid_misc, 11'h0);
			thr = (i == 0) ? 11'h7FF : (i == 1) ? ctx[11:1] : 11'($urandom_range(0, 1200));
			v = 8'($urandom);
			apb(1'b1, `ICR_OFS_CONTROL, {19'h0, md == 2'd2, md == 2'd1, thr});
			apb(1'b1, `ICR_OFS_VECTOR, {24'h0, v});
			repeat (4) @(posedge pclk);
			ctx = exp_ctx(bid_rx, bid_tx, bid_misc, thr);
			chk("request_n", 32'(ctx == 12'h0), 32'(irq_request_n));
			if (i % 2 == 0) begin
				i_icr_host_model.ack(i % 4, vv, ok);
				chk("vec_valid", 32'h1, 32'(ok));
				chk("vector", 32'(exp_vec(v, ctx, md)), 32'(vv));
			end else
				apb(1'b1, `ICR_OFS_CONTEXT, 32'($urandom));
			repeat (4) @(posedge pclk);
			bid_rx <= ~bid_rx;
			repeat (4) @(posedge pclk);
			apb(1'b0, `ICR_OFS_CONTEXT, 32'h0);
			chk("context", {20'h0, ctx}, rd);
			apb(1'b0, `ICR_OFS_GTYPE, 32'h0);
			chk("type", {28'h0, ctx[4:1]}, rd);
			if (ctx[4:1] == `ICR_TYPE_RX_OK) begin
				apb(1'b0, `ICR_OFS_GBYTECNT, 32'h0);
				chk("byte_count", {24'h0, rx_level}, rd);
				apb(1'b0, `ICR_OFS_GCHAN, 32'h0);
				chk("channel", 32'h0, rd);
				apb(1'b0, `ICR_OFS_GRXDATA, 32'h0);
				chk("rx_data", {24'h0, rx_fifo_data}, rd);
			end
			if (ctx[4:1] == `ICR_TYPE_TX) begin
				apb(1'b1, `ICR_OFS_GTXDATA, {24'h0, v});
				repeat (2) @(posedge pclk);
				chk("tx_data", {24'h0, v}, {24'h0, tx_fifo_data});
			end
		end
		apb(1'b1, `ICR_OFS_ADDRCH, 32'h55);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, `ICR_OFS_MODE0, 32'(m) << `ICR_MODE0_STRIP_LSB);
			for (int k = 0; k < 6; k++) begin
				send(chars[k % 3], k > 2);
				chk("store", 32'(!strip(m, k % 3) || k > 2), 32'(ch_store));
				chk("event", 32'(1 << (k % 3)), 32'(recog_event));
				apb(1'b0, `ICR_OFS_RECOG, 32'h0);
				chk("recog_set", 32'(1 << (k % 3)), rd);
				apb(1'b0, `ICR_OFS_RECOG, 32'h0);
				chk("recog_status", 32'h0, rd);
			end
		end
		send(8'h41, 1'b0);
		chk("plain_event", 32'h0, 32'(recog_event));
		print_verdict();
	end
endmodule
`default_nettype wire
